// >>> hdl/sfl_params.svh
// Offsets, field positions, reset values and timing counts for the status flag latch.
`ifndef SFL_PARAMS_SVH
`define SFL_PARAMS_SVH

`define SFL_STATUS_ADDR 7'h01
`define SFL_CMD_READ 1'b1
`define SFL_CMD_BITS 6'h08
`define SFL_FRAME_BITS 6'h20
`define SFL_WORD_MSB 23

`define SFL_BIT_GENMON 15
`define SFL_BIT_PACE_FIFO_INT 14
`define SFL_BIT_PACE_FIFO_OVERFLOW 13
`define SFL_BIT_PACE_EDGE_FLAG 12
`define SFL_BIT_LON 11
`define SFL_BIT_RR 10
`define SFL_BIT_SAMPLE_SYNC_PULSE 9
`define SFL_BIT_PLL 8
`define SFL_BIT_POSDRV 5
`define SFL_BIT_NEGDRV 4
`define SFL_STATUS_LOW_RESET 16'h0000

`define SFL_ULP_LON_MODE_A 2'h1
`define SFL_ULP_LON_MODE_B 2'h2
`define SFL_RR_CLR_SELF 2'h1
`define SFL_CLR_SELF 1'b1
`define SFL_SELF_CLR_CYCLES 4'h8

`define SFL_GEN_LEADOFF_MS 128
`define SFL_CLK_KHZ 10000

`endif

// >>> hdl/sfl_pkg.sv
// Types shared by the status flag latch modules.
package sfl_pkg;

	typedef enum logic [2:0]
	{
		SFL_LON_OFF = 3'b001,
		SFL_LON_WAIT = 3'b010,
		SFL_LON_ARMED = 3'b100
	} sfl_lon_state_t;

endpackage

// >>> hdl/sfl_serial_port.sv
// Serial port slave that shifts out the status word and reports the clearing clock.
`timescale 1ns/1ps
`include "sfl_params.svh"
module sfl_serial_port
	import sfl_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Serial pins
	input wire logic sclk_in,
	input wire logic csb_b_in,
	input wire logic sdi_in,
	output logic sdo_out,
	// Status word
	input wire logic [23:0] word_in,
	output logic read_done_out,
	output logic [23:0] snapshot_out
);

	logic [2:0] sclk_s_q;
	logic [1:0] csb_b_s_q;
	logic [1:0] sdi_s_q;
	logic [5:0] cnt_q;
	logic [7:0] cmd_q;
	logic [23:0] shift_q;
	logic rd_ok_q;

	wire rise = sclk_s_q[1] & ~sclk_s_q[2];
	wire fall = ~sclk_s_q[1] & sclk_s_q[2];
	wire active = ~csb_b_s_q[1];
	wire [7:0] cmd_next = {cmd_q[6:0], sdi_s_q[1]};
	wire cmd_last = rise & (cnt_q == `SFL_CMD_BITS - 6'h01);
	wire status_hit = cmd_last & (cmd_next == {`SFL_STATUS_ADDR, `SFL_CMD_READ});
	wire frame_last = rise & rd_ok_q & (cnt_q == `SFL_FRAME_BITS - 6'h01);

	// Pins cross into the clock domain through two flip-flops before any edge detection.
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			sclk_s_q <= 3'h0;
			csb_b_s_q <= 2'h3;
			sdi_s_q <= 2'h0;
		end
		else
		begin
			sclk_s_q <= {sclk_s_q[1:0], sclk_in};
			csb_b_s_q <= {csb_b_s_q[0], csb_b_in};
			sdi_s_q <= {sdi_s_q[0], sdi_in};
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in || !active)
		begin
			cnt_q <= 6'h00;
			cmd_q <= 8'h00;
			rd_ok_q <= 1'b0;
		end
		else if (rise)
		begin
			if (cnt_q != `SFL_FRAME_BITS)
				cnt_q <= cnt_q + 6'h01;
			if (cnt_q < `SFL_CMD_BITS)
				cmd_q <= cmd_next;
			if (status_hit)
				rd_ok_q <= 1'b1;
		end
	end

	// Data leaves on the falling edge so that the host samples it on the rising edge.
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			shift_q <= 24'h000000;
			snapshot_out <= 24'h000000;
			sdo_out <= 1'b0;
		end
		else if (status_hit)
		begin
			shift_q <= word_in;
			snapshot_out <= word_in;
		end
		else if (!active)
			sdo_out <= 1'b0;
		else if (fall && rd_ok_q)
		begin
			sdo_out <= shift_q[`SFL_WORD_MSB];
			shift_q <= {shift_q[22:0], 1'b0};
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			read_done_out <= 1'b0;
		else
			read_done_out <= frame_last;
	end

endmodule

// >>> hdl/sfl_status_latch.sv
// Lower sixteen bits of the status word: sticky flags, lead-off timers and leads-on arming.
`timescale 1ns/1ps
`include "sfl_params.svh"
// Overview of operation
// - Bit 15 sets after either drive generator is lead-off for 128 ms.
// - Sticky flags other than bit 13 follow their condition, then hold until the 32nd clock of a read or their self-clear.
// - Bit 14 is high while any pace record waits to be read.
// - Bit 13 sets on pace overflow and holds until FIFO reset or synchronise.
// - Bit 12 follows live pace edges; clearing obeys the pace edge clear mode.
// - Bit 11 asserts when the leads-on enable field becomes 01 or 10.
// - Once armed, bit 11 follows leads-on and then holds until a status read.
// - Bit 10 sets on each new R event; clearing obeys the R-event clear mode.
// - Bit 9 pulses on base-rate instants at the selected interval and clear mode.
// - Bit 8 reports PLL unlock only while the ECG or BioZ channel runs.
// - Bits 5 and 4 report each generator lead-off for 128 ms.
// - Bits 3..0: positive high, positive low, negative high, negative low.
// - Bits 3..0 set with the DC lead-off interrupt while DC lead-off detection is enabled, and hold until a read.
// - Every flag is active high whether or not its interrupt is enabled.
module sfl_status_latch
	import sfl_pkg::*;
#(
	parameter int unsigned GEN_LEADOFF_CYCLES = `SFL_GEN_LEADOFF_MS * `SFL_CLK_KHZ
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Serial port
	input wire logic sclk_in,
	input wire logic csb_b_in,
	input wire logic sdi_in,
	output logic sdo_out,
	// Upper status byte from neighbouring logic
	input wire logic [7:0] status_high_in,
	// Drive generator comparators
	input wire logic pos_drive_output_leadoff_in,
	input wire logic neg_drive_output_leadoff_in,
	// Pace logic
	input wire logic pace_records_avail_in,
	input wire logic pace_overflow_evt_in,
	input wire logic fifo_reset_in,
	input wire logic synchronise_command_in,
	input wire logic pace_edge_evt_in,
	input wire logic pace_edge_clear_mode_in,
	// R-event and sample timing
	input wire logic r_event_evt_in,
	input wire logic [1:0] r_event_clear_mode_in,
	input wire logic sample_instant_in,
	input wire logic [1:0] sample_interval_sel_in,
	input wire logic sample_clear_mode_in,
	// PLL and channel power
	input wire logic pll_locked_in,
	input wire logic ecg_enable_in,
	input wire logic bioz_enable_in,
	// Leads-on detection
	input wire logic [1:0] ulp_leads_on_enable_in,
	input wire logic leads_on_detect_in,
	// DC lead-off detection
	input wire logic dc_leadoff_int_in,
	input wire logic dc_leadoff_detect_en_in,
	input wire logic pos_above_high_in,
	input wire logic pos_below_low_in,
	input wire logic neg_above_high_in,
	input wire logic neg_below_low_in,
	// Status flags
	output logic [15:0] status_low_out
);

	localparam logic [20:0] GEN_LIM = 21'(GEN_LEADOFF_CYCLES - 1);

	function automatic logic sticky(input logic set, input logic held, input logic clr);
		return set | (held & ~clr);
	endfunction

	logic [15:0] status_low_q;
	logic [15:0] status_low_d;
	logic [7:0] meta_q;
	logic [7:0] sync_q;
	logic [3:0] sample_sync_pulse_div_q;
	sfl_lon_state_t lon_q;
	sfl_lon_state_t lon_d;
	logic rd_done;
	logic [23:0] snap;
	logic [1:0] gen_met;
	logic [2:0] mode_d;

	wire [7:0] async_raw = {pll_locked_in, leads_on_detect_in, pos_drive_output_leadoff_in,
		neg_drive_output_leadoff_in, pos_above_high_in, pos_below_low_in, neg_above_high_in, neg_below_low_in};
	wire pll_locked = sync_q[7];
	wire leads_on = sync_q[6];
	wire [1:0] gen_off = sync_q[5:4];
	wire [3:0] ldoff_cmp = sync_q[3:0];

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			meta_q <= 8'h00;
			sync_q <= 8'h00;
		end
		else
		begin
			meta_q <= async_raw;
			sync_q <= meta_q;
		end
	end

	sfl_serial_port u_port
	(
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.sclk_in(sclk_in),
		.csb_b_in(csb_b_in),
		.sdi_in(sdi_in),
		.sdo_out(sdo_out),
		.word_in({status_high_in, status_low_q}),
		.read_done_out(rd_done),
		.snapshot_out(snap)
	);

	// A read clears only the bits it reported, so a flag that rose mid-frame survives.
	wire [15:0] rd_clr = {16{rd_done}} & snap[15:0];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_gen
			logic [20:0] cnt_q;
			always_ff @(posedge clk_in)
			begin
				if (!rst_b_in || !gen_off[gi])
					cnt_q <= 21'h00000;
				else if (cnt_q != GEN_LIM)
					cnt_q <= cnt_q + 21'h00001;
			end
			assign gen_met[gi] = gen_off[gi] & (cnt_q == GEN_LIM);
		end
	endgenerate

	// Flags with a selectable clear: 0 is pace edge, 1 is R event, 2 is sample pulse.
	function automatic logic [3:0] sample_sync_pulse_last(input logic [1:0] sel);
		return (sel == 2'h0) ? 4'h0 : (sel == 2'h1) ? 4'h1 : (sel == 2'h2) ? 4'h3 : 4'hf;
	endfunction

	wire sample_sync_pulse_fire = sample_instant_in & (sample_sync_pulse_div_q == sample_sync_pulse_last(sample_interval_sel_in));
	wire [2:0] mode_set = {sample_sync_pulse_fire, r_event_evt_in, pace_edge_evt_in};
	wire [2:0] mode_self = {sample_clear_mode_in == `SFL_CLR_SELF, r_event_clear_mode_in == `SFL_RR_CLR_SELF,
		pace_edge_clear_mode_in == `SFL_CLR_SELF};
	wire [2:0] mode_q = {status_low_q[`SFL_BIT_SAMPLE_SYNC_PULSE], status_low_q[`SFL_BIT_RR], status_low_q[`SFL_BIT_PACE_EDGE_FLAG]};
	wire [2:0] mode_rd = {rd_clr[`SFL_BIT_SAMPLE_SYNC_PULSE], rd_clr[`SFL_BIT_RR], rd_clr[`SFL_BIT_PACE_EDGE_FLAG]};

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			sample_sync_pulse_div_q <= 4'h0;
		else if (sample_sync_pulse_fire)
			sample_sync_pulse_div_q <= 4'h0;
		else if (sample_instant_in)
			sample_sync_pulse_div_q <= sample_sync_pulse_div_q + 4'h1;
	end

	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_mode
			logic [3:0] age_q;
			wire aged = age_q == `SFL_SELF_CLR_CYCLES - 4'h1;
			wire clr = mode_self[gi] ? (mode_q[gi] & aged) : mode_rd[gi];
			always_ff @(posedge clk_in)
			begin
				if (!rst_b_in || mode_set[gi] || !mode_q[gi])
					age_q <= 4'h0;
				else if (!aged)
					age_q <= age_q + 4'h1;
			end
			assign mode_d[gi] = sticky(mode_set[gi], mode_q[gi], clr);
		end
	endgenerate

	// Leads-on arming: enabling raises the flag, the next read arms live detection.
	wire ulp_on = (ulp_leads_on_enable_in == `SFL_ULP_LON_MODE_A) | (ulp_leads_on_enable_in == `SFL_ULP_LON_MODE_B);
	wire lon_set = ((lon_q == SFL_LON_OFF) & ulp_on) | ((lon_q == SFL_LON_ARMED) & leads_on);

	always_comb
	begin
		lon_d = lon_q;
		unique case (lon_q)
			SFL_LON_OFF:
				if (ulp_on)
					lon_d = SFL_LON_WAIT;
			SFL_LON_WAIT:
				if (!ulp_on)
					lon_d = SFL_LON_OFF;
				else if (rd_clr[`SFL_BIT_LON])
					lon_d = SFL_LON_ARMED;
			SFL_LON_ARMED:
				if (!ulp_on)
					lon_d = SFL_LON_OFF;
			default:
				lon_d = SFL_LON_OFF;
		endcase
	end

	wire genmon_d = sticky(|gen_met, status_low_q[`SFL_BIT_GENMON], rd_clr[`SFL_BIT_GENMON]);
	wire pace_fifo_int_d = pace_records_avail_in;
	wire pace_fifo_overflow_d = sticky(pace_overflow_evt_in, status_low_q[`SFL_BIT_PACE_FIFO_OVERFLOW],
		fifo_reset_in | synchronise_command_in);
	wire lon_flag_d = sticky(lon_set, status_low_q[`SFL_BIT_LON], rd_clr[`SFL_BIT_LON]);
	wire pll_d = sticky((ecg_enable_in | bioz_enable_in) & ~pll_locked, status_low_q[`SFL_BIT_PLL],
		rd_clr[`SFL_BIT_PLL]);
	wire posdrv_d = sticky(gen_met[1], status_low_q[`SFL_BIT_POSDRV], rd_clr[`SFL_BIT_POSDRV]);
	wire negdrv_d = sticky(gen_met[0], status_low_q[`SFL_BIT_NEGDRV], rd_clr[`SFL_BIT_NEGDRV]);
	wire [3:0] ld_set = {4{dc_leadoff_int_in & dc_leadoff_detect_en_in}} & ldoff_cmp;
	wire [3:0] ld_d = ld_set | (status_low_q[3:0] & ~rd_clr[3:0]);

	assign status_low_d = {genmon_d, pace_fifo_int_d, pace_fifo_overflow_d, mode_d[0], lon_flag_d, mode_d[1], mode_d[2], pll_d,
		2'b00, posdrv_d, negdrv_d, ld_d};

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			status_low_q <= `SFL_STATUS_LOW_RESET;
			lon_q <= SFL_LON_OFF;
		end
		else
		begin
			status_low_q <= status_low_d;
			lon_q <= lon_d;
		end
	end

	assign status_low_out = status_low_q;

endmodule

// >>> verif/sfl_host_model.sv
// Host model that runs mode-0 serial frames against the status port.
`timescale 1ns/1ps
module sfl_host_model
(
	// Clock
	input wire logic clk_in,
	// Serial pins
	output logic sclk_out,
	output logic csb_b_out,
	output logic sdi_out,
	input wire logic sdo_in
);
	initial
	begin
		sclk_out = 1'b0;
		csb_b_out = 1'b1;
		sdi_out = 1'b0;
	end
	// Clocks nr rises of a frame and returns the data bits; fewer than 32 rises abort it.
	task automatic xfer(input logic [7:0] cmd, input int nr, output logic [23:0] d);
		d = '0;
		@(negedge clk_in);
		csb_b_out = 1'b0;
		for (int i = 0; i < nr; i++)
		begin
			sdi_out = (i < 8) ? cmd[7 - i] : ~sdi_out;
			repeat (4) @(negedge clk_in);
			sclk_out = 1'b1;
			repeat (4) @(negedge clk_in);
			if (i >= 8)
				d[31 - i] = sdo_in;
			sclk_out = 1'b0;
		end
		repeat (4) @(negedge clk_in);
		csb_b_out = 1'b1;
		sdi_out = ~sdi_out;
		repeat (6) @(negedge clk_in);
	endtask
endmodule

// >>> verif/sfl_status_latch_checker.sv
// Concurrent checks on the lower status flags, bound to the status latch.
`timescale 1ns/1ps
module sfl_status_latch_checker
#(
	parameter int unsigned GEN_LEADOFF_CYCLES = 20
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Watched inputs
	input wire logic csb_b_in,
	input wire logic pos_drive_output_leadoff_in,
	input wire logic pace_records_avail_in,
	input wire logic pace_overflow_evt_in,
	input wire logic fifo_reset_in,
	input wire logic synchronise_command_in,
	input wire logic pll_locked_in,
	input wire logic ecg_enable_in,
	input wire logic bioz_enable_in,
	input wire logic dc_leadoff_int_in,
	input wire logic dc_leadoff_detect_en_in,
	input wire logic pos_above_high_in,
	// Watched outputs
	input wire logic [15:0] status_low_out
);
	int unsigned pos_q;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// Counts how long the positive generator has been lead-off, saturating past the timer.
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in || !pos_drive_output_leadoff_in)
			pos_q <= 0;
		else if (pos_q < GEN_LEADOFF_CYCLES + 8)
			pos_q <= pos_q + 1;
	end
	a_spare_bits_zero: assert property (status_low_out[7:6] == 2'b00) else $error("spare bits set");
	a_pace_int_follows: assert property (1'b1 |=> status_low_out[14] == $past(pace_records_avail_in))
		else $error("pace flag does not follow records");
	a_ovf_sets: assert property (pace_overflow_evt_in |=> status_low_out[13]) else $error("overflow not set");
	a_ovf_clears: assert property ((fifo_reset_in || synchronise_command_in) && !pace_overflow_evt_in
		|=> !status_low_out[13]) else $error("overflow not cleared");
	a_pll_unlock_sets: assert property (((ecg_enable_in || bioz_enable_in) && !pll_locked_in) [*4]
		|=> status_low_out[8]) else $error("unlock not set");
	a_pll_needs_power: assert property (!ecg_enable_in && !bioz_enable_in && !status_low_out[8]
		|=> !status_low_out[8]) else $error("unlock set while unpowered");
	a_gen_timer_sets: assert property (pos_q == GEN_LEADOFF_CYCLES + 2
		|-> status_low_out[15] && status_low_out[5]) else $error("generator lead-off not set");
	a_gen_not_early: assert property (pos_q == GEN_LEADOFF_CYCLES + 1 && !$past(status_low_out[5])
		|-> !status_low_out[5]) else $error("generator lead-off set early");
	a_dc_detail_sets: assert property ((dc_leadoff_int_in && dc_leadoff_detect_en_in && pos_above_high_in) [*4]
		|=> status_low_out[3]) else $error("lead-off detail not set");
	a_sticky_flag_hold: assert property (csb_b_in [*6]
		|=> (~status_low_out & $past(status_low_out) & 16'h893f) == 16'h0000) else $error("sticky flag lost");
endmodule
bind sfl_status_latch sfl_status_latch_checker #(.GEN_LEADOFF_CYCLES(GEN_LEADOFF_CYCLES)) u_chk (.*);

// >>> verif/sfl_status_latch_tb.sv
// Self-checking bench for the lower status flags.
`timescale 1ns/1ps
module sfl_status_latch_tb;
	localparam int G = 20;
	logic clk_in, rst_b_in, sclk_in, csb_b_in, sdi_in, sdo_out;
	logic [7:0] status_high_in;
	logic pos_drive_output_leadoff_in, neg_drive_output_leadoff_in, pace_records_avail_in, pace_overflow_evt_in;
	logic fifo_reset_in, synchronise_command_in, pace_edge_evt_in, pace_edge_clear_mode_in, r_event_evt_in;
	logic [1:0] r_event_clear_mode_in, sample_interval_sel_in, ulp_leads_on_enable_in;
	logic sample_instant_in, sample_clear_mode_in, pll_locked_in, ecg_enable_in, bioz_enable_in, leads_on_detect_in;
	logic dc_leadoff_int_in, dc_leadoff_detect_en_in, pos_above_high_in, pos_below_low_in, neg_above_high_in;
	logic neg_below_low_in;
	logic [15:0] status_low_out;
	logic [23:0] w;
	int fail_count = 0;
	int n_checks = 0;
	sfl_status_latch #(.GEN_LEADOFF_CYCLES(G)) dut (.*);
	sfl_host_model host (.clk_in(clk_in), .sclk_out(sclk_in), .csb_b_out(csb_b_in), .sdi_out(sdi_in), .sdo_in(sdo_out));
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(2);
	endtask
	task automatic ev(input logic [2:0] v);
		{pace_edge_evt_in, r_event_evt_in, sample_instant_in} = v;
		cyc(1);
		{pace_edge_evt_in, r_event_evt_in, sample_instant_in} = 3'h0;
		cyc(2);
	endtask
	task automatic lo(input logic [15:0] e);
		chk("flags", {8'h00, e}, {8'h00, status_low_out});
	endtask
	task automatic rdchk(input logic [15:0] e);
		host.xfer(8'h03, 32, w);
		chk("word", {8'ha5, e}, w);
	endtask
	task automatic t_pace;
		pace_records_avail_in = 1'b1;
		cyc(2);
		rdchk(16'h4000);
		pace_records_avail_in = 1'b0;
		pulse(pace_overflow_evt_in);
		rdchk(16'h2000);
		lo(16'h2000);
		pulse(fifo_reset_in);
		lo(16'h0000);
		pulse(pace_overflow_evt_in);
		pulse(synchronise_command_in);
		lo(16'h0000);
		$display("test pace done");
	endtask
	task automatic t_events;
		ev(3'h7);
		rdchk(16'h1600);
		lo(16'h0000);
		{pace_edge_clear_mode_in, r_event_clear_mode_in, sample_clear_mode_in} = 4'hb;
		ev(3'h7);
		lo(16'h1600);
		cyc(12);
		lo(16'h0000);
		{pace_edge_clear_mode_in, r_event_clear_mode_in, sample_clear_mode_in} = 4'h0;
		ev(3'h4);
		host.xfer(8'h03, 20, w);
		host.xfer(8'h05, 32, w);
		chk("other", 24'h000000, w);
		rdchk(16'h1000);
		sample_interval_sel_in = 2'h2;
		repeat (3) ev(3'h1);
		lo(16'h0000);
		ev(3'h1);
		lo(16'h0200);
		rdchk(16'h0200);
		sample_interval_sel_in = 2'h0;
		$display("test events done");
	endtask
	task automatic t_pll_leads;
		pll_locked_in = 1'b0;
		cyc(6);
		lo(16'h0000);
		bioz_enable_in = 1'b1;
		cyc(6);
		bioz_enable_in = 1'b0;
		pll_locked_in = 1'b1;
		rdchk(16'h0100);
		pll_locked_in = 1'b0;
		ecg_enable_in = 1'b1;
		cyc(6);
		ecg_enable_in = 1'b0;
		pll_locked_in = 1'b1;
		rdchk(16'h0100);
		for (int m = 1; m < 3; m++)
		begin
			ulp_leads_on_enable_in = m[1:0];
			cyc(4);
			rdchk(16'h0800);
			lo(16'h0000);
			leads_on_detect_in = 1'b1;
			cyc(5);
			leads_on_detect_in = 1'b0;
			ulp_leads_on_enable_in = 2'h0;
			cyc(5);
			rdchk(16'h0800);
		end
		$display("test pll and leads-on done");
	endtask
	task automatic t_leadoff;
		int i;
		neg_drive_output_leadoff_in = 1'b1;
		cyc(G - 5);
		neg_drive_output_leadoff_in = 1'b0;
		lo(16'h0000);
		pos_drive_output_leadoff_in = 1'b1;
		for (i = 0; i < G + 20 && status_low_out[15] !== 1'b1; i++)
			cyc(1);
		if (i == G + 20)
		begin
			fail_count++;
			stop_test();
		end
		pos_drive_output_leadoff_in = 1'b0;
		cyc(4);
		rdchk(16'h8020);
		neg_drive_output_leadoff_in = 1'b1;
		cyc(G + 10);
		neg_drive_output_leadoff_in = 1'b0;
		rdchk(16'h8010);
		{dc_leadoff_int_in, dc_leadoff_detect_en_in} = 2'h2;
		{pos_above_high_in, pos_below_low_in, neg_above_high_in, neg_below_low_in} = 4'hf;
		cyc(5);
		lo(16'h0000);
		{pos_above_high_in, pos_below_low_in, neg_above_high_in, neg_below_low_in} = 4'h0;
		cyc(3);
		{dc_leadoff_int_in, dc_leadoff_detect_en_in} = 2'h3;
		for (i = 0; i < 4; i++)
		begin
			{pos_above_high_in, pos_below_low_in, neg_above_high_in, neg_below_low_in} = 4'h8 >> i;
			cyc(5);
			{pos_above_high_in, pos_below_low_in, neg_above_high_in, neg_below_low_in} = 4'h0;
			rdchk(16'h0008 >> i);
		end
		lo(16'h0000);
		$display("test lead-off done");
	endtask
	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	initial
	begin
		{rst_b_in, pos_drive_output_leadoff_in, neg_drive_output_leadoff_in, pace_records_avail_in} = '0;
		{pace_overflow_evt_in, fifo_reset_in, synchronise_command_in, pace_edge_evt_in, r_event_evt_in} = '0;
		{pace_edge_clear_mode_in, r_event_clear_mode_in, sample_interval_sel_in, ulp_leads_on_enable_in} = '0;
		{sample_instant_in, sample_clear_mode_in, ecg_enable_in, bioz_enable_in, leads_on_detect_in} = '0;
		{dc_leadoff_int_in, dc_leadoff_detect_en_in, pos_above_high_in, pos_below_low_in} = '0;
		{neg_above_high_in, neg_below_low_in} = '0;
		pll_locked_in = 1'b1;
		status_high_in = 8'ha5;
		cyc(6);
		rst_b_in = 1'b1;
		cyc(3);
		lo(16'h0000);
		t_pace();
		t_events();
		t_pll_leads();
		t_leadoff();
		stop_test();
	end
endmodule
